// ---- rtl/epsm_loader.sv ----
// image-to-configuration field loader for three switch ports
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "epsm_regs.svh"
// Overview of operation
// R1: aux current from image bits 3:1
// R2: image bit 4 to D1 support
// R3: image bit 5 to D2 support
// R4: PME D1/D2 support from bits 7:6
// R5: PM data from image bits 15:8
// R6: ports 1,2 skip-soft-reset from words 52h,54h
// R7: port 0 slot clock from word 60h
// R8: device-specific init from image bit 2
// R9: VC1 low-priority count from bit 3
// R10: logical port number from bits 6:4
// R11: TC-to-VC0 map from bits 15:9
// R12: port 0 skip-soft-reset from word 50h
// R13: fields ready first; defaults without image
module epsm_loader (
  input  wire logic        core_clk,   // 25 MHz core clock
  input  wire logic        resetn,     // async reset, active low
  input  wire logic [7:0]  addr,       // register index
  input  wire logic [31:0] wdata,      // write data
  input  wire logic        wr,         // write strobe
  input  wire logic        rd,         // read strobe
  output logic      [31:0] rdata,      // read data, cycle after rd
  output logic             cfg_ready   // ports may accept config requests
);
  import epsm_pkg::*;

  epsm_state_s_t s_r;
  epsm_state_s_t s_nxt;

  localparam logic [2:0][15:0] SLOT_DEF = {`EPSM_SLOT_DEFAULT_P2, `EPSM_SLOT_DEFAULT_P1,
                                           `EPSM_SLOT_DEFAULT_P0};

  // mapped configuration fields of one port
  function automatic logic [31:0] cfg40(input epsm_port_img_t p);
    cfg40 = 32'h0;
    cfg40[24:22] = p.nsr[3:1];  // [R1]
    cfg40[25]    = p.nsr[4];    // [R2]
    cfg40[26]    = p.nsr[5];    // [R3]
    cfg40[29:28] = p.nsr[7:6];  // [R4]
    cfg40[21]    = p.slot[2];   // [R8]
  endfunction

  function automatic logic [31:0] cfg44(input epsm_port_img_t p);
    cfg44 = 32'h0;
    cfg44[31:24] = p.nsr[15:8]; // [R5]
    cfg44[3]     = p.nsr[0];    // [R6] [R12]
  endfunction

  function automatic logic [31:0] cfg_sel(input epsm_port_img_t p, input logic [7:0] a);
    cfg_sel = 32'h0;
    case (a)
      `EPSM_REG_CFG_40:  cfg_sel = cfg40(p);
      `EPSM_REG_CFG_44:  cfg_sel = cfg44(p);
      `EPSM_REG_CFG_D0:  cfg_sel = {3'h0, p.slot[1], 28'h0};       // [R7]
      `EPSM_REG_CFG_144: cfg_sel = {27'h0, p.slot[3], 4'h0};       // [R9]
      `EPSM_REG_CFG_CC:  cfg_sel = {5'h0, p.slot[6:4], 24'h0};     // [R10]
      `EPSM_REG_CFG_154: cfg_sel = {24'h0, p.slot[15:9], 1'b0};    // [R11]
      `EPSM_REG_CFG_LLC: cfg_sel = {16'h0, p.llc};
      default:           cfg_sel = 32'h0;
    endcase
  endfunction

  // image word address to port and word kind
  function automatic logic [3:0] img_decode(input logic [7:0] a);
    case (a)
      `EPSM_IMG_NSR_P0:  img_decode = 4'h0;
      `EPSM_IMG_NSR_P1:  img_decode = 4'h1;
      `EPSM_IMG_NSR_P2:  img_decode = 4'h2;
      `EPSM_IMG_LLC_P0:  img_decode = 4'h4;
      `EPSM_IMG_LLC_P1:  img_decode = 4'h5;
      `EPSM_IMG_LLC_P2:  img_decode = 4'h6;
      `EPSM_IMG_SLOT_P0: img_decode = 4'h8;
      `EPSM_IMG_SLOT_P1: img_decode = 4'h9;
      `EPSM_IMG_SLOT_P2: img_decode = 4'ha;
      default:           img_decode = 4'hf;
    endcase
  endfunction

  logic [3:0] dec;
  assign dec = img_decode(s_r.img_addr);

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h0;
    if (wr) begin
      case (addr)
        `EPSM_REG_CTRL: begin
          // loader finished; invalid image restores defaults
          if (wdata[`EPSM_CTRL_DONE_BIT] && s_r.st == EPSM_IDLE) begin
            s_nxt.st = EPSM_DONE;
            s_nxt.cfg_ready = 1'b1;                              // [R13]
            if (!wdata[`EPSM_CTRL_VALID_BIT]) begin
              for (int i = 0; i < 3; i++) begin
                s_nxt.img[i].nsr  = `EPSM_NSR_DEFAULT;           // [R13]
                s_nxt.img[i].llc  = `EPSM_LLC_DEFAULT;
                s_nxt.img[i].slot = SLOT_DEF[i];
              end
            end
          end
        end
        `EPSM_REG_IMG_ADDR: s_nxt.img_addr = wdata[7:0];
        `EPSM_REG_IMG_DATA: begin
          // image words land only before the ports open
          if (s_r.st == EPSM_IDLE && dec != 4'hf) begin
            case (dec[3:2])
              2'h0:    s_nxt.img[dec[1:0]].nsr  = wdata[15:0];   // [R6] [R12]
              2'h1:    s_nxt.img[dec[1:0]].llc  = wdata[15:0];
              default: s_nxt.img[dec[1:0]].slot = wdata[15:0];   // [R7]
            endcase
          end
        end
        `EPSM_REG_PORT_SEL: s_nxt.port_sel = (wdata[1:0] == 2'h3) ? 2'h0 : wdata[1:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        `EPSM_REG_CTRL:      s_nxt.rdata = 32'h0;
        `EPSM_REG_STATUS:    s_nxt.rdata = {30'h0, s_r.st == EPSM_DONE, s_r.cfg_ready};
        `EPSM_REG_IMG_ADDR:  s_nxt.rdata = {24'h0, s_r.img_addr};
        `EPSM_REG_PORT_SEL:  s_nxt.rdata = {30'h0, s_r.port_sel};
        default:             s_nxt.rdata = cfg_sel(s_r.img[s_r.port_sel], addr);
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_r.st        <= EPSM_IDLE;
      s_r.img[0]    <= {`EPSM_NSR_DEFAULT, `EPSM_LLC_DEFAULT, `EPSM_SLOT_DEFAULT_P0};
      s_r.img[1]    <= {`EPSM_NSR_DEFAULT, `EPSM_LLC_DEFAULT, `EPSM_SLOT_DEFAULT_P1};
      s_r.img[2]    <= {`EPSM_NSR_DEFAULT, `EPSM_LLC_DEFAULT, `EPSM_SLOT_DEFAULT_P2};
      s_r.img_addr  <= 8'h00;
      s_r.port_sel  <= 2'h0;
      s_r.rdata     <= 32'h0;
      s_r.cfg_ready <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata     = s_r.rdata;
  assign cfg_ready = s_r.cfg_ready;

  a_ready_needs_done: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
    s_r.cfg_ready |-> s_r.st == EPSM_DONE) else $error("ready before load done");
  a_ready_sticks: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
    s_r.cfg_ready |=> s_r.cfg_ready) else $error("ready dropped");
  a_img_frozen: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
    (s_r.st == EPSM_DONE && $past(s_r.st) == EPSM_DONE) |-> $stable(s_r.img)) else $error("image changed");
  a_pm_cap_map: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
    (rd && addr == `EPSM_REG_CFG_40) |=> rdata[29:21] ==
      {$past(s_r.img[s_r.port_sel].nsr[7:6]), 1'b0, $past(s_r.img[s_r.port_sel].nsr[5:1]),
       $past(s_r.img[s_r.port_sel].slot[2])}) else $error("pm cap field wrong");
  a_pm_data_map: assert property (@(posedge core_clk) disable iff (!resetn) // [R5]
    (rd && addr == `EPSM_REG_CFG_44) |=>
      rdata == {$past(s_r.img[s_r.port_sel].nsr[15:8]), 20'h0, $past(s_r.img[s_r.port_sel].nsr[0]), 3'h0})
    else $error("pm data field wrong");
  a_slot_clk_map: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
    (rd && addr == `EPSM_REG_CFG_D0) |=> rdata[28] == $past(s_r.img[s_r.port_sel].slot[1]))
    else $error("slot clock wrong");
  a_vc_map: assert property (@(posedge core_clk) disable iff (!resetn) // [R11]
    (rd && addr == `EPSM_REG_CFG_154) |=> rdata[7:1] == $past(s_r.img[s_r.port_sel].slot[15:9]))
    else $error("tc map wrong");
  a_port_num_map: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
    (rd && addr == `EPSM_REG_CFG_CC) |=> rdata[26:24] == $past(s_r.img[s_r.port_sel].slot[6:4]))
    else $error("port number wrong");
  a_low_pri_vc_map: assert property (@(posedge core_clk) disable iff (!resetn) // [R9]
    (rd && addr == `EPSM_REG_CFG_144) |=> rdata[4] == $past(s_r.img[s_r.port_sel].slot[3]))
    else $error("low priority vc count wrong");
  a_nsr_p1_load: assert property (@(posedge core_clk) disable iff (!resetn) // [R6]
    (wr && addr == `EPSM_REG_IMG_DATA && s_r.st == EPSM_IDLE && s_r.img_addr == `EPSM_IMG_NSR_P1)
      |=> s_r.img[1].nsr == $past(wdata[15:0])) else $error("port1 word not loaded");
  a_nsr_p0_load: assert property (@(posedge core_clk) disable iff (!resetn) // [R12]
    (wr && addr == `EPSM_REG_IMG_DATA && s_r.st == EPSM_IDLE && s_r.img_addr == `EPSM_IMG_NSR_P0)
      |=> s_r.img[0].nsr == $past(wdata[15:0])) else $error("port0 word not loaded");
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (!resetn)
    !$past(rd) |-> rdata == 32'h0) else $error("stray read data");

  // per-port loads, default restore and field views
  for (genvar g = 0; g < 3; g++) begin : g_port
    localparam logic [7:0] NSR_A  = 8'(`EPSM_IMG_NSR_P0 + 2 * g);
    localparam logic [7:0] LLC_A  = 8'(`EPSM_IMG_LLC_P0 + 2 * g);
    localparam logic [7:0] SLOT_A = 8'(`EPSM_IMG_SLOT_P0 + 2 * g);
    localparam logic [1:0] SEL    = 2'(g);

    logic img_wr;
    logic restore;
    assign img_wr  = wr && addr == `EPSM_REG_IMG_DATA && s_r.st == EPSM_IDLE;
    assign restore = wr && addr == `EPSM_REG_CTRL && wdata[`EPSM_CTRL_DONE_BIT]
                     && !wdata[`EPSM_CTRL_VALID_BIT] && s_r.st == EPSM_IDLE;

    a_nsr_load: assert property (@(posedge core_clk) disable iff (!resetn) // [R6] [R12]
      (img_wr && s_r.img_addr == NSR_A)
      |=> s_r.img[g].nsr == $past(wdata[15:0]))
      else $error("pm word not loaded");

    a_llc_load: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
      (img_wr && s_r.img_addr == LLC_A)
      |=> s_r.img[g].llc == $past(wdata[15:0]))
      else $error("link word not loaded");

    a_slot_load: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
      (img_wr && s_r.img_addr == SLOT_A)
      |=> s_r.img[g].slot == $past(wdata[15:0]))
      else $error("slot word not loaded");

    a_nsr_restore: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
      restore
      |=> s_r.img[g].nsr == `EPSM_NSR_DEFAULT)
      else $error("pm word default lost");

    a_llc_restore: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
      restore
      |=> s_r.img[g].llc == `EPSM_LLC_DEFAULT)
      else $error("link word default lost");

    a_slot_restore: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
      restore
      |=> s_r.img[g].slot == SLOT_DEF[g])
      else $error("slot word default lost");

    a_aux_cur_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
      (rd && addr == `EPSM_REG_CFG_40 && s_r.port_sel == SEL)
      |=> rdata[24:22] == $past(s_r.img[g].nsr[3:1]))
      else $error("aux current wrong");

    a_d1_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
      (rd && addr == `EPSM_REG_CFG_40 && s_r.port_sel == SEL)
      |=> rdata[25] == $past(s_r.img[g].nsr[4]))
      else $error("d1 support wrong");

    a_d2_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R3]
      (rd && addr == `EPSM_REG_CFG_40 && s_r.port_sel == SEL)
      |=> rdata[26] == $past(s_r.img[g].nsr[5]))
      else $error("d2 support wrong");

    a_pme_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R4]
      (rd && addr == `EPSM_REG_CFG_40 && s_r.port_sel == SEL)
      |=> rdata[29:28] == $past(s_r.img[g].nsr[7:6]))
      else $error("pme support wrong");

    a_dsi_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R8]
      (rd && addr == `EPSM_REG_CFG_40 && s_r.port_sel == SEL)
      |=> rdata[21] == $past(s_r.img[g].slot[2]))
      else $error("dev init flag wrong");

    a_pm_rsvd_zero: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
      (rd && addr == `EPSM_REG_CFG_40 && s_r.port_sel == SEL)
      |=> rdata[31:30] == 2'h0 && rdata[27] == 1'b0 && rdata[20:0] == 21'h0)
      else $error("pm cap unmapped bits set");

    a_pm_data_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R5]
      (rd && addr == `EPSM_REG_CFG_44 && s_r.port_sel == SEL)
      |=> rdata[31:24] == $past(s_r.img[g].nsr[15:8]))
      else $error("pm data wrong");

    a_skip_rst_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R6] [R12]
      (rd && addr == `EPSM_REG_CFG_44 && s_r.port_sel == SEL)
      |=> rdata[3] == $past(s_r.img[g].nsr[0]))
      else $error("skip soft reset wrong");

    a_cfg44_rsvd_zero: assert property (@(posedge core_clk) disable iff (!resetn) // [R5]
      (rd && addr == `EPSM_REG_CFG_44 && s_r.port_sel == SEL)
      |=> rdata[23:4] == 20'h0 && rdata[2:0] == 3'h0)
      else $error("pm data unmapped bits set");

    a_slot_clk_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
      (rd && addr == `EPSM_REG_CFG_D0 && s_r.port_sel == SEL)
      |=> rdata == {3'h0, $past(s_r.img[g].slot[1]), 28'h0})
      else $error("slot clock view wrong");

    a_low_pri_vc_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R9]
      (rd && addr == `EPSM_REG_CFG_144 && s_r.port_sel == SEL)
      |=> rdata == {27'h0, $past(s_r.img[g].slot[3]), 4'h0})
      else $error("low priority vc view wrong");

    a_port_num_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
      (rd && addr == `EPSM_REG_CFG_CC && s_r.port_sel == SEL)
      |=> rdata == {5'h0, $past(s_r.img[g].slot[6:4]), 24'h0})
      else $error("port number view wrong");

    a_tc_map_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R11]
      (rd && addr == `EPSM_REG_CFG_154 && s_r.port_sel == SEL)
      |=> rdata == {24'h0, $past(s_r.img[g].slot[15:9]), 1'b0})
      else $error("tc map view wrong");

    a_llc_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
      (rd && addr == `EPSM_REG_CFG_LLC && s_r.port_sel == SEL)
      |=> rdata == {16'h0, $past(s_r.img[g].llc)})
      else $error("link word view wrong");
  end

  a_ready_on_done: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
    (wr && addr == `EPSM_REG_CTRL && wdata[`EPSM_CTRL_DONE_BIT] && s_r.st == EPSM_IDLE)
    |=> s_r.cfg_ready && s_r.st == EPSM_DONE)
    else $error("ready not raised on done");

  a_done_holds: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
    s_r.st == EPSM_DONE
    |=> s_r.st == EPSM_DONE)
    else $error("load state left done");

  a_late_word_ignored: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
    (wr && addr == `EPSM_REG_IMG_DATA && s_r.st == EPSM_DONE)
    |=> $stable(s_r.img))
    else $error("late image word landed");

  a_port_sel_clamp: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr && addr == `EPSM_REG_PORT_SEL && wdata[1:0] == 2'h3)
    |=> s_r.port_sel == 2'h0)
    else $error("port select not clamped");

  a_img_addr_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr && addr == `EPSM_REG_IMG_ADDR)
    |=> s_r.img_addr == $past(wdata[7:0]))
    else $error("image address not loaded");

  a_status_view: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
    (rd && addr == `EPSM_REG_STATUS)
    |=> rdata == {30'h0, $past(s_r.st == EPSM_DONE), $past(s_r.cfg_ready)})
    else $error("status view wrong");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd && (addr == `EPSM_REG_CTRL || addr == `EPSM_REG_IMG_DATA
            || (addr > `EPSM_REG_PORT_SEL && addr < `EPSM_REG_CFG_40) || addr > `EPSM_REG_CFG_LLC))
    |=> rdata == 32'h0)
    else $error("unmapped index read nonzero");

  c_load_done: cover property (@(posedge core_clk) disable iff (!resetn) $rose(s_r.cfg_ready));
  c_word_load: cover property (@(posedge core_clk) disable iff (!resetn)
    wr && addr == `EPSM_REG_IMG_DATA && s_r.st == EPSM_IDLE && dec != 4'hf);
  c_cfg_read: cover property (@(posedge core_clk) disable iff (!resetn)
    rd && addr == `EPSM_REG_CFG_40 && s_r.cfg_ready);
  c_invalid_image: cover property (@(posedge core_clk) disable iff (!resetn)
    wr && addr == `EPSM_REG_CTRL && wdata[`EPSM_CTRL_DONE_BIT] && !wdata[`EPSM_CTRL_VALID_BIT]);
  c_port2_view: cover property (@(posedge core_clk) disable iff (!resetn)
    rd && addr == `EPSM_REG_CFG_154 && s_r.port_sel == 2'h2);
endmodule

// ---- rtl/epsm_pkg.sv ----
// types for the config image loader
package epsm_pkg;
  typedef enum logic [1:0] {
    EPSM_IDLE = 2'b01,
    EPSM_DONE = 2'b10
  } epsm_state_t;

  typedef struct packed {
    logic [15:0] nsr;
    logic [15:0] llc;
    logic [15:0] slot;
  } epsm_port_img_t;

  typedef struct packed {
    epsm_state_t        st;
    epsm_port_img_t [2:0] img;
    logic [7:0]         img_addr;
    logic [1:0]         port_sel;
    logic [31:0]        rdata;
    logic               cfg_ready;
  } epsm_state_s_t;
endpackage

// ---- rtl/epsm_regs.svh ----
// image word addresses, field positions and defaults for the config image loader
`ifndef EPSM_REGS_SVH
`define EPSM_REGS_SVH
`define EPSM_IMG_NSR_P0        8'h50
`define EPSM_IMG_NSR_P1        8'h52
`define EPSM_IMG_NSR_P2        8'h54
`define EPSM_IMG_LLC_P0        8'h58
`define EPSM_IMG_LLC_P1        8'h5a
`define EPSM_IMG_LLC_P2        8'h5c
`define EPSM_IMG_SLOT_P0       8'h60
`define EPSM_IMG_SLOT_P1       8'h62
`define EPSM_IMG_SLOT_P2       8'h64
`define EPSM_NSR_DEFAULT       16'h00ff
`define EPSM_LLC_DEFAULT       16'h0004
`define EPSM_SLOT_DEFAULT_P0   16'hfe02
`define EPSM_SLOT_DEFAULT_P1   16'hfe12
`define EPSM_SLOT_DEFAULT_P2   16'hfe22
`define EPSM_REG_CTRL          8'h00
`define EPSM_REG_STATUS        8'h01
`define EPSM_REG_IMG_ADDR      8'h02
`define EPSM_REG_IMG_DATA      8'h03
`define EPSM_REG_PORT_SEL      8'h04
`define EPSM_REG_CFG_40        8'h10
`define EPSM_REG_CFG_44        8'h11
`define EPSM_REG_CFG_D0        8'h12
`define EPSM_REG_CFG_144       8'h13
`define EPSM_REG_CFG_CC        8'h14
`define EPSM_REG_CFG_154       8'h15
`define EPSM_REG_CFG_LLC       8'h16
`define EPSM_CTRL_DONE_BIT     0
`define EPSM_CTRL_VALID_BIT    1
`endif

// ---- verification/epsm_image_mem.sv ----
// behavioural model of the external configuration image memory
`timescale 1ns/100ps
module epsm_image_mem (
  input  wire logic        clk,   // core clock
  input  wire logic [7:0]  addr,  // image word address
  input  wire logic        we,    // preload strobe
  input  wire logic [15:0] wd,    // preload word
  output logic      [15:0] data   // word at addr
);
  logic [15:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 16'hffff; // blank part reads all ones
  always @(posedge clk) if (we) mem[addr] <= wd;
  assign data = mem[addr];
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the config image loader
`timescale 1ns/100ps
`include "epsm_regs.svh"
module testbench;
  logic        core_clk, resetn, wr, rd, rd_q, m_we, cfg_ready;
  logic [7:0]  addr, m_addr;
  logic [31:0] wdata, rdata;
  logic [15:0] m_wd, m_data, d;
  logic [15:0] nsr [3], llc [3], slot [3];
  logic [31:0] exp_q [$];
  integer      seed, miscompares, checks;
  epsm_loader dut (.core_clk(core_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
                   .rd(rd), .rdata(rdata), .cfg_ready(cfg_ready));
  epsm_image_mem mem (.clk(core_clk), .addr(m_addr), .we(m_we), .wd(m_wd), .data(m_data));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] expd);
    checks++;
    if (seen !== expd) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, expd, seen);
    end
  endtask
  task automatic bus_wr(logic [7:0] a, logic [31:0] v);
    @(posedge core_clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    rd <= 1'b1; addr <= a; exp_q.push_back(e);
    @(posedge core_clk);
    rd <= 1'b0;
  endtask
  function automatic logic [31:0] view(int i, int p);
    logic [15:0] n, s;
    n = nsr[p]; s = slot[p];
    case (i)
      0: view = {2'h0, n[7:6], 1'b0, n[5], n[4], n[3:1], s[2], 21'h0};
      1: view = {n[15:8], 20'h0, n[0], 3'h0};
      2: view = {3'h0, s[1], 28'h0};
      3: view = {27'h0, s[3], 4'h0};
      4: view = {5'h0, s[6:4], 24'h0};
      5: view = {24'h0, s[15:9], 1'b0};
      default: view = {16'h0, llc[p]};
    endcase
  endfunction
  task automatic set_defaults();
    for (int p = 0; p < 3; p++) begin
      nsr[p] = `EPSM_NSR_DEFAULT; llc[p] = `EPSM_LLC_DEFAULT;
    end
    slot[0] = `EPSM_SLOT_DEFAULT_P0; slot[1] = `EPSM_SLOT_DEFAULT_P1; slot[2] = `EPSM_SLOT_DEFAULT_P2;
  endtask
  task automatic read_all();
    for (int p = 0; p < 3; p++) begin
      bus_wr(`EPSM_REG_PORT_SEL, 32'(p));
      for (int i = 0; i < 7; i++) bus_rd(8'h10 + 8'(i), view(i, p));
    end
  endtask
  // copy words 50/58/60 + 2*port from the image memory; ctl bit1 marks image valid
  task automatic load(logic [31:0] ctl);
    for (int p = 0; p < 3; p++)
      for (int k = 0; k < 3; k++) begin
        d = 16'($random(seed));
        @(posedge core_clk);
        m_we <= 1'b1; m_addr <= 8'h50 + 8'(8 * k + 2 * p); m_wd <= d;
        @(posedge core_clk);
        m_we <= 1'b0;
        bus_wr(`EPSM_REG_IMG_ADDR, {24'h0, m_addr});
        bus_wr(`EPSM_REG_IMG_DATA, {16'h0, m_data});
        if (ctl[1]) case (k)
          0: nsr[p] = d;
          1: llc[p] = d;
          default: slot[p] = d;
        endcase
      end
    bus_wr(`EPSM_REG_CTRL, ctl);
    @(negedge core_clk);
    check("cfg_ready", {31'h0, cfg_ready}, 32'h1);
  endtask
  always @(posedge core_clk) rd_q <= rd;
  always @(negedge core_clk) if (rd_q) check("rdata", rdata, exp_q.pop_front());
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
  initial begin
    seed = 6; miscompares = 0; checks = 0;
    resetn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h0; wdata = 32'h0;
    m_we = 1'b0; m_addr = 8'h0; m_wd = 16'h0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    set_defaults();
    @(negedge core_clk);
    check("cfg_ready", {31'h0, cfg_ready}, 32'h0);
    read_all();
    load(32'h3);
    read_all();
    // late image writes change nothing; an out-of-range port select falls back to port 0
    bus_wr(`EPSM_REG_IMG_ADDR, 32'h52);
    bus_wr(`EPSM_REG_IMG_DATA, {16'h0, ~nsr[1]});
    bus_wr(`EPSM_REG_PORT_SEL, 32'h3);
    bus_rd(`EPSM_REG_CFG_44, view(1, 0));
    bus_rd(8'h05, 32'h0);
    bus_wr(`EPSM_REG_PORT_SEL, 32'h1);
    bus_rd(`EPSM_REG_CFG_44, view(1, 1));
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    set_defaults();
    load(32'h1);
    read_all();
    repeat (3) @(posedge core_clk);
    summarize();
  end
endmodule
